// [uart_regsel_consts.vh]
// Constants for the dual-channel register select and loopback block
`ifndef UART_REGSEL_CONSTS_VH
`define UART_REGSEL_CONSTS_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define NUM_CH         2
`define ADDR_W         3
`define DATA_W         8

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADR_0          3'h0
`define ADR_1          3'h1
`define ADR_2          3'h2
`define ADR_3          3'h3
`define ADR_4          3'h4
`define ADR_5          3'h5
`define ADR_6          3'h6
`define ADR_7          3'h7

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define LCR_ENH_VALUE  8'hBF
`define LCR_DLAB_BIT   7
`define EFR_ENH_BIT    4
`define FEATURE_CONTROL_SEL_BIT   6
`define MCR_LOOP_BIT   4
`define MCR_DTR_BIT    0
`define MCR_RTS_BIT    1
`define MCR_OP1_BIT    2
`define MCR_OP2_BIT    3
`define RX_READY_BIT   0
`define IER_ENH_MASK   8'hF0
`define MCR_ENH_MASK   8'hE0
`define FCR_ENH_MASK   8'h30
`define ISR_ENH_MASK   8'h30
`define REG_RESET      8'h00
`define DIV_ZERO       8'h00
`define MARK_LEVEL     1'h1
`define OUT_INACTIVE   1'h1
`define MODEM_PIN_IDLE 5'h1F
`define MSR_ZERO       4'h0

`endif

// [pin_sync.v]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'h0}}
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_n,
  // Pin side and synchronised side
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      stage_one <= INIT;
      sync_out  <= INIT;
    end else begin
      stage_one <= pin_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// [two_entry_buffer.v]
// Two-entry valid/ready buffer
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst_n,
  // Filling side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output reg              in_ready,
  // Draining side
  output wire [WIDTH-1:0] out_data,
  output reg              out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem [0:1];
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  reg [1:0]       next_count;
  wire            push;
  wire            pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_ready & out_valid;
  assign out_data = mem[rd_ptr];

  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr    <= 1'h0;
      rd_ptr    <= 1'h0;
      count     <= 2'h0;
      in_ready  <= 1'h0;
      out_valid <= 1'h0;
      mem[0]    <= {WIDTH{1'h0}};
      mem[1]    <= {WIDTH{1'h0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count     <= next_count;
      in_ready  <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
    end
  end

endmodule

// [uart_register_select_loopback.v]
// Register decode and internal loopback for a dual UART
`timescale 1ns/1ps
`include "uart_regsel_consts.vh"
module uart_register_select_loopback #(
  parameter                CHANNEL_SELECT_MODE     = 0,
  // Identity values below are arbitrary
  parameter [`DATA_W-1:0]  REVISION_CODE  = 8'h01,
  parameter [`DATA_W-1:0]  DEVICE_ID_CODE = 8'h5A
) (
  // Clock and reset
  input  wire                          core_clk,
  input  wire                          rst_n,
  // Host parallel bus
  input  wire [`ADDR_W-1:0]            bus_addr,
  input  wire [`DATA_W-1:0]            bus_data_in,
  output reg  [`DATA_W-1:0]            bus_data_out,
  output reg                           bus_data_oe_n,
  input  wire                          bus_wr_n,
  input  wire                          bus_rd_n,
  input  wire [`NUM_CH-1:0]            chip_select_n,
  input  wire                          channel_select,
  // Transmit word stream to the shifter
  output wire [`NUM_CH*`DATA_W-1:0]    tx_data,
  output wire [`NUM_CH-1:0]            tx_valid,
  input  wire [`NUM_CH-1:0]            tx_ready,
  // Receive word stream from the shifter
  input  wire [`NUM_CH*`DATA_W-1:0]    rx_data,
  input  wire [`NUM_CH-1:0]            rx_valid,
  output wire [`NUM_CH-1:0]            rx_ready,
  // Status from the channel core
  input  wire [`NUM_CH*`DATA_W-1:0]    interrupt_status_in,
  input  wire [`NUM_CH*`DATA_W-1:0]    line_status_in,
  input  wire [`NUM_CH*`DATA_W-1:0]    fifo_level_in,
  // Configuration to the channel core
  output wire [`NUM_CH*`DATA_W-1:0]    line_control,
  output wire [`NUM_CH*`DATA_W-1:0]    interrupt_enable,
  output wire [`NUM_CH*`DATA_W-1:0]    modem_control,
  output wire [`NUM_CH*`DATA_W-1:0]    divisor_low,
  output wire [`NUM_CH*`DATA_W-1:0]    divisor_high,
  output wire [`NUM_CH*`DATA_W-1:0]    divisor_fraction,
  output wire [`NUM_CH*`DATA_W-1:0]    alternate_function,
  output wire [`NUM_CH*`DATA_W-1:0]    enhanced_function,
  output wire [`NUM_CH*`DATA_W-1:0]    feature_control,
  output wire [`NUM_CH*`DATA_W-1:0]    enhanced_mode_select,
  output wire [`NUM_CH*`DATA_W-1:0]    fifo_control,
  output wire [`NUM_CH-1:0]            fifo_control_strobe,
  output wire [`NUM_CH*`DATA_W-1:0]    trigger_level,
  output wire [`NUM_CH-1:0]            trigger_level_strobe,
  output wire [`NUM_CH*2*`DATA_W-1:0]  xon_chars,
  output wire [`NUM_CH*2*`DATA_W-1:0]  xoff_chars,
  // Serial path to the shifters
  input  wire [`NUM_CH-1:0]            core_tx_serial,
  output wire [`NUM_CH-1:0]            core_rx_serial,
  output wire [`NUM_CH-1:0]            flow_cts_active,
  // Serial and modem pins
  output wire [`NUM_CH-1:0]            tx_pin,
  input  wire [`NUM_CH-1:0]            rx_pin,
  output wire [`NUM_CH-1:0]            rts_n_pin,
  output wire [`NUM_CH-1:0]            dtr_n_pin,
  input  wire [`NUM_CH-1:0]            cts_n_pin,
  input  wire [`NUM_CH-1:0]            dsr_n_pin,
  input  wire [`NUM_CH-1:0]            carrier_detect_in_n,
  input  wire [`NUM_CH-1:0]            ring_indicator_in_n
);

  // ----------------------------------------
  // Bus pin synchronisation
  // ----------------------------------------
  localparam SYNC_W = `ADDR_W + `DATA_W + `NUM_CH + 3;

  wire [`ADDR_W-1:0] s_addr;
  wire [`DATA_W-1:0] s_data;
  wire [`NUM_CH-1:0] s_cs_n;
  wire               s_channel_select;
  wire               s_wr_n;
  wire               s_rd_n;
  reg                wr_prev_n;
  reg                rd_prev_n;
  reg  [`NUM_CH-1:0] sel;
  wire               any_sel;
  wire               write_take;
  wire               read_take;
  wire [`NUM_CH*`DATA_W-1:0] rd_vec;

  pin_sync #(
    .WIDTH (SYNC_W),
    .INIT  ({{(`ADDR_W+`DATA_W){1'h0}}, {`NUM_CH{1'h1}}, 3'h3})
  ) u_bus_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({bus_addr, bus_data_in, chip_select_n, channel_select, bus_wr_n, bus_rd_n}),
    .sync_out ({s_addr, s_data, s_cs_n, s_channel_select, s_wr_n, s_rd_n})
  );

  // Channel selection by chip selects or by channel select line
  always @* begin
    sel = {`NUM_CH{1'h0}};
    if (CHANNEL_SELECT_MODE == 0) begin
      sel = ~s_cs_n;
    end else begin
      sel[0] = ~s_cs_n[0] & ~s_channel_select;
      sel[1] = ~s_cs_n[0] & s_channel_select;
    end
  end

  assign any_sel    = |sel;
  assign write_take = wr_prev_n & ~s_wr_n & any_sel;
  assign read_take  = rd_prev_n & ~s_rd_n & any_sel;

  // ----------------------------------------
  // Bus read data and strobe edges
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_prev_n     <= 1'h1;
      rd_prev_n     <= 1'h1;
      bus_data_out  <= `REG_RESET;
      bus_data_oe_n <= 1'h1;
    end else begin
      wr_prev_n <= s_wr_n;
      rd_prev_n <= s_rd_n;
      if (read_take) begin
        bus_data_out  <= sel[1] ? rd_vec[`DATA_W +: `DATA_W] : rd_vec[0 +: `DATA_W];
        bus_data_oe_n <= 1'h0;
      end else if (s_rd_n) begin
        bus_data_oe_n <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Per-channel register sets
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_CH; ch = ch + 1) begin : chan
      reg  [`DATA_W-1:0] lcr_q;
      reg  [`DATA_W-1:0] ier_q;
      reg  [`DATA_W-1:0] mcr_q;
      reg  [`DATA_W-1:0] dll_q;
      reg  [`DATA_W-1:0] dlm_q;
      reg  [`DATA_W-1:0] dld_q;
      reg  [`DATA_W-1:0] afr_q;
      reg  [`DATA_W-1:0] efr_q;
      reg  [`DATA_W-1:0] feature_control_q;
      reg  [`DATA_W-1:0] enhanced_mode_select_q;
      reg  [`DATA_W-1:0] spr_q;
      reg  [`DATA_W-1:0] fcr_q;
      reg  [`DATA_W-1:0] trg_q;
      reg  [`DATA_W-1:0] xon1_q;
      reg  [`DATA_W-1:0] xon2_q;
      reg  [`DATA_W-1:0] xoff1_q;
      reg  [`DATA_W-1:0] xoff2_q;
      reg  [`DATA_W-1:0] txd_q;
      reg                txv_q;
      reg                fcr_stb_q;
      reg                trg_stb_q;
      reg  [3:0]         msr_delta;
      reg  [3:0]         modem_prev;
      reg                tx_pin_q;
      reg                rts_pin_q;
      reg                dtr_pin_q;
      reg                rx_ser_q;
      reg                cts_flow_q;
      reg  [`DATA_W-1:0] rd_val;
      reg  [`DATA_W-1:0] enh_keep;
      wire               we;
      wire               re;
      wire               bank_bf;
      wire               bank_div;
      wire               enh_on;
      wire               div_zero;
      wire               loop_on;
      wire [4:0]         s_modem;
      wire [3:0]         modem_now;
      wire [`DATA_W-1:0] rx_head;
      wire               rx_head_valid;
      wire               rx_pop;
      wire               msr_read;

      assign we       = write_take & sel[ch];
      assign re       = read_take & sel[ch];
      assign bank_bf  = (lcr_q == `LCR_ENH_VALUE);
      assign bank_div = lcr_q[`LCR_DLAB_BIT] & ~bank_bf;
      assign enh_on   = efr_q[`EFR_ENH_BIT];
      assign div_zero = (dll_q == `DIV_ZERO) && (dlm_q == `DIV_ZERO);
      assign loop_on  = mcr_q[`MCR_LOOP_BIT];
      assign rx_pop   = re && (s_addr == `ADR_0) && !bank_bf && !bank_div;
      assign msr_read = re && (s_addr == `ADR_6) && !bank_bf;

      // Receive words pass a two-entry buffer before the holding register
      two_entry_buffer #(
        .WIDTH (`DATA_W)
      ) u_rx_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_data   (rx_data[ch*`DATA_W +: `DATA_W]),
        .in_valid  (rx_valid[ch]),
        .in_ready  (rx_ready[ch]),
        .out_data  (rx_head),
        .out_valid (rx_head_valid),
        .out_ready (rx_pop)
      );

      pin_sync #(
        .WIDTH (5),
        .INIT  (`MODEM_PIN_IDLE)
      ) u_modem_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   ({rx_pin[ch], carrier_detect_in_n[ch], ring_indicator_in_n[ch], dsr_n_pin[ch], cts_n_pin[ch]}),
        .sync_out (s_modem)
      );

      // Modem inputs follow modem control in loopback
      assign modem_now = loop_on ? {mcr_q[`MCR_OP2_BIT], mcr_q[`MCR_OP1_BIT],
                                    mcr_q[`MCR_DTR_BIT], mcr_q[`MCR_RTS_BIT]}
                                 : ~s_modem[3:0];

      // Enhanced bits are kept only when enhanced functions are on
      always @* begin
        enh_keep = enh_on ? {`DATA_W{1'h1}} : {`DATA_W{1'h0}};
      end

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      always @(posedge core_clk) begin
        if (!rst_n) begin
          lcr_q     <= `REG_RESET;
          ier_q     <= `REG_RESET;
          mcr_q     <= `REG_RESET;
          dll_q     <= `REG_RESET;
          dlm_q     <= `REG_RESET;
          dld_q     <= `REG_RESET;
          afr_q     <= `REG_RESET;
          efr_q     <= `REG_RESET;
          feature_control_q    <= `REG_RESET;
          enhanced_mode_select_q    <= `REG_RESET;
          spr_q     <= `REG_RESET;
          fcr_q     <= `REG_RESET;
          trg_q     <= `REG_RESET;
          xon1_q    <= `REG_RESET;
          xon2_q    <= `REG_RESET;
          xoff1_q   <= `REG_RESET;
          xoff2_q   <= `REG_RESET;
          txd_q     <= `REG_RESET;
          txv_q     <= 1'h0;
          fcr_stb_q <= 1'h0;
          trg_stb_q <= 1'h0;
        end else begin
          fcr_stb_q <= 1'h0;
          trg_stb_q <= 1'h0;
          if (txv_q && tx_ready[ch]) begin
            txv_q <= 1'h0;
          end
          if (we) begin
            case (s_addr)
              `ADR_0: begin
                if (bank_bf) begin
                  trg_q     <= s_data;
                  trg_stb_q <= 1'h1;
                end else if (bank_div) begin
                  dll_q <= s_data;
                end else begin
                  txd_q <= s_data;
                  txv_q <= 1'h1;
                end
              end
              `ADR_1: begin
                if (bank_bf) begin
                  feature_control_q <= s_data;
                end else if (bank_div) begin
                  dlm_q <= s_data;
                end else begin
                  ier_q <= s_data & (~`IER_ENH_MASK | enh_keep);
                end
              end
              `ADR_2: begin
                if (bank_bf) begin
                  efr_q <= s_data;
                end else if (bank_div && enh_on) begin
                  dld_q <= s_data;
                end else if (bank_div) begin
                  afr_q <= s_data;
                end else begin
                  fcr_q     <= s_data & (~`FCR_ENH_MASK | enh_keep);
                  fcr_stb_q <= 1'h1;
                end
              end
              `ADR_3: begin
                lcr_q <= s_data;
              end
              `ADR_4: begin
                if (bank_bf) begin
                  xon1_q <= s_data;
                end else begin
                  mcr_q <= s_data & (~`MCR_ENH_MASK | enh_keep);
                end
              end
              `ADR_5: begin
                if (bank_bf) begin
                  xon2_q <= s_data;
                end
              end
              `ADR_6: begin
                if (bank_bf) begin
                  xoff1_q <= s_data;
                end
              end
              `ADR_7: begin
                if (bank_bf) begin
                  xoff2_q <= s_data;
                end else if (feature_control_q[`FEATURE_CONTROL_SEL_BIT]) begin
                  enhanced_mode_select_q <= s_data;
                end else begin
                  spr_q <= s_data;
                end
              end
              default: begin
                lcr_q <= lcr_q;
              end
            endcase
          end
        end
      end

      // ----------------------------------------
      // Register reads
      // ----------------------------------------
      always @* begin
        rd_val = `REG_RESET;
        case (s_addr)
          `ADR_0: begin
            if (bank_bf) begin
              rd_val = fifo_level_in[ch*`DATA_W +: `DATA_W];
            end else if (bank_div) begin
              rd_val = div_zero ? REVISION_CODE : dll_q;
            end else begin
              rd_val = rx_head;
            end
          end
          `ADR_1: begin
            if (bank_bf) begin
              rd_val = feature_control_q;
            end else if (bank_div) begin
              rd_val = div_zero ? DEVICE_ID_CODE : dlm_q;
            end else begin
              rd_val = ier_q;
            end
          end
          `ADR_2: begin
            if (bank_bf) begin
              rd_val = efr_q;
            end else if (bank_div) begin
              rd_val = enh_on ? dld_q : afr_q;
            end else begin
              rd_val = interrupt_status_in[ch*`DATA_W +: `DATA_W] & (~`ISR_ENH_MASK | enh_keep);
            end
          end
          `ADR_3: begin
            rd_val = lcr_q;
          end
          `ADR_4: begin
            rd_val = bank_bf ? xon1_q : mcr_q;
          end
          `ADR_5: begin
            if (bank_bf) begin
              rd_val = xon2_q;
            end else begin
              rd_val = line_status_in[ch*`DATA_W +: `DATA_W];
              rd_val[`RX_READY_BIT] = rx_head_valid;
            end
          end
          `ADR_6: begin
            rd_val = bank_bf ? xoff1_q : {modem_now, msr_delta};
          end
          `ADR_7: begin
            if (bank_bf) begin
              rd_val = xoff2_q;
            end else if (feature_control_q[`FEATURE_CONTROL_SEL_BIT]) begin
              rd_val = fifo_level_in[ch*`DATA_W +: `DATA_W];
            end else begin
              rd_val = spr_q;
            end
          end
          default: begin
            rd_val = `REG_RESET;
          end
        endcase
      end

      // ----------------------------------------
      // Modem status deltas and loopback pins
      // ----------------------------------------
      always @(posedge core_clk) begin
        if (!rst_n) begin
          msr_delta  <= `MSR_ZERO;
          modem_prev <= `MSR_ZERO;
          tx_pin_q   <= `MARK_LEVEL;
          rts_pin_q  <= `OUT_INACTIVE;
          dtr_pin_q  <= `OUT_INACTIVE;
          rx_ser_q   <= `MARK_LEVEL;
          cts_flow_q <= 1'h0;
        end else begin
          modem_prev <= modem_now;
          msr_delta  <= (msr_read ? `MSR_ZERO : msr_delta) | (modem_now ^ modem_prev);
          tx_pin_q   <= loop_on ? `MARK_LEVEL : core_tx_serial[ch];
          rts_pin_q  <= loop_on ? `OUT_INACTIVE : ~mcr_q[`MCR_RTS_BIT];
          dtr_pin_q  <= loop_on ? `OUT_INACTIVE : ~mcr_q[`MCR_DTR_BIT];
          rx_ser_q   <= loop_on ? core_tx_serial[ch] : s_modem[4];
          cts_flow_q <= ~loop_on & ~s_modem[0];
        end
      end

      assign rd_vec[ch*`DATA_W +: `DATA_W]                 = rd_val;
      assign line_control[ch*`DATA_W +: `DATA_W]           = lcr_q;
      assign interrupt_enable[ch*`DATA_W +: `DATA_W]       = ier_q;
      assign modem_control[ch*`DATA_W +: `DATA_W]          = mcr_q;
      assign divisor_low[ch*`DATA_W +: `DATA_W]            = dll_q;
      assign divisor_high[ch*`DATA_W +: `DATA_W]           = dlm_q;
      assign divisor_fraction[ch*`DATA_W +: `DATA_W]       = dld_q;
      assign alternate_function[ch*`DATA_W +: `DATA_W]     = afr_q;
      assign enhanced_function[ch*`DATA_W +: `DATA_W]      = efr_q;
      assign feature_control[ch*`DATA_W +: `DATA_W]        = feature_control_q;
      assign enhanced_mode_select[ch*`DATA_W +: `DATA_W]   = enhanced_mode_select_q;
      assign fifo_control[ch*`DATA_W +: `DATA_W]           = fcr_q;
      assign fifo_control_strobe[ch]                       = fcr_stb_q;
      assign trigger_level[ch*`DATA_W +: `DATA_W]          = trg_q;
      assign trigger_level_strobe[ch]                      = trg_stb_q;
      assign xon_chars[ch*2*`DATA_W +: 2*`DATA_W]          = {xon2_q, xon1_q};
      assign xoff_chars[ch*2*`DATA_W +: 2*`DATA_W]         = {xoff2_q, xoff1_q};
      assign tx_data[ch*`DATA_W +: `DATA_W]                = txd_q;
      assign tx_valid[ch]                                  = txv_q;
      assign tx_pin[ch]                                    = tx_pin_q;
      assign rts_n_pin[ch]                                 = rts_pin_q;
      assign dtr_n_pin[ch]                                 = dtr_pin_q;
      assign core_rx_serial[ch]                            = rx_ser_q;
      assign flow_cts_active[ch]                           = cts_flow_q;
    end
  endgenerate

endmodule

// [uart_regsel_sva.sv]
// Port checker for register select and loopback
`timescale 1ns/1ps
`include "uart_regsel_consts.vh"
module uart_regsel_sva (
  // Clock and reset
  input wire                       core_clk,
  input wire                       rst_n,
  // Bus
  input wire                       bus_rd_n,
  input wire                       bus_wr_n,
  input wire                       bus_data_oe_n,
  input wire [`NUM_CH*`DATA_W-1:0] line_control,
  input wire [`NUM_CH*`DATA_W-1:0] modem_control,
  input wire [`NUM_CH-1:0]         fifo_control_strobe,
  // Serial and pins
  input wire [`NUM_CH-1:0]         core_tx_serial,
  input wire [`NUM_CH-1:0]         core_rx_serial,
  input wire [`NUM_CH-1:0]         flow_cts_active,
  input wire [`NUM_CH-1:0]         tx_pin,
  input wire [`NUM_CH-1:0]         rts_n_pin,
  input wire [`NUM_CH-1:0]         dtr_n_pin
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  wire lp = modem_control[4];
  property p_tx_loop; $past(lp) |-> tx_pin[0]; endproperty
  property p_mo_loop; $past(lp) |-> rts_n_pin[0] && dtr_n_pin[0]; endproperty
  property p_rx_loop; $past(lp) |-> core_rx_serial[0] == $past(core_tx_serial[0]); endproperty
  property p_tx_norm; !$past(lp) |-> tx_pin[0] == $past(core_tx_serial[0]); endproperty
  property p_rts_norm; !$past(lp) |-> rts_n_pin[0] == !$past(modem_control[1]); endproperty
  property p_cts_off; $past(lp) |-> !flow_cts_active[0]; endproperty
  property p_strobe; fifo_control_strobe[0] |-> !$past(bus_wr_n, 2) ##1 !fifo_control_strobe[0]; endproperty
  property p_oe_fall; $fell(bus_data_oe_n) |-> !$past(bus_rd_n, 2); endproperty
  property p_oe_rise; bus_rd_n [*5] |=> bus_data_oe_n; endproperty
  property p_lcr; $changed(line_control) |-> !$past(bus_wr_n, 2); endproperty
  a_tx_loop: assert property (p_tx_loop) else $error("tx pin not held");
  a_mo_loop: assert property (p_mo_loop) else $error("modem outputs not held");
  a_rx_loop: assert property (p_rx_loop) else $error("loop path broken");
  a_tx_norm: assert property (p_tx_norm) else $error("tx pin wrong");
  a_rts_norm: assert property (p_rts_norm) else $error("rts pin wrong");
  a_cts_off: assert property (p_cts_off) else $error("cts active in loop");
  a_strobe: assert property (p_strobe) else $error("strobe too long");
  a_oe_fall: assert property (p_oe_fall) else $error("drive without read");
  a_oe_rise: assert property (p_oe_rise) else $error("drive not released");
  a_lcr: assert property (p_lcr) else $error("line control changed alone");
  c_loop: cover property ($rose(lp));
  c_fcr: cover property (fifo_control_strobe[0]);
  c_read: cover property ($fell(bus_data_oe_n));
endmodule

// [host_bus_model.sv]
// Host model driving the parallel register pins
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input  wire        core_clk,
  // Parallel bus
  output logic [2:0] bus_addr = 3'h0,
  output logic [7:0] bus_data_in = 8'h00,
  output logic       bus_wr_n = 1'h1,
  output logic       bus_rd_n = 1'h1,
  output logic [1:0] chip_select_n = 2'h3,
  output logic       channel_select = 1'h0,
  input  wire  [7:0] bus_data_out
);
  task automatic acc(input logic c, w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    bus_addr = a;
    bus_data_in = d;
    chip_select_n = c ? 2'h1 : 2'h2;
    repeat (3) @(negedge core_clk);
    bus_wr_n = !w;
    bus_rd_n = w;
    repeat (6) @(negedge core_clk);
    q = bus_data_out;
    bus_wr_n = 1'h1;
    bus_rd_n = 1'h1;
    repeat (4) @(negedge core_clk);
    bus_data_in = ~d;
    chip_select_n = 2'h3;
  endtask
endmodule

// [uart_register_select_loopback_tb.sv]
// Testbench for register select and loopback
`timescale 1ns/1ps
module uart_register_select_loopback_tb;
  logic        core_clk = 1'h0;
  logic        rst_n = 1'h0;
  wire  [2:0]  bus_addr;
  wire  [7:0]  bus_data_in, bus_data_out;
  wire         bus_wr_n, bus_rd_n, channel_select, bus_data_oe_n;
  wire  [1:0]  chip_select_n, tx_valid, rx_ready, fifo_control_strobe, trigger_level_strobe;
  wire  [1:0]  core_rx_serial, flow_cts_active, tx_pin, rts_n_pin, dtr_n_pin;
  wire  [15:0] tx_data, line_control, interrupt_enable, modem_control, divisor_low, divisor_high;
  wire  [15:0] divisor_fraction, alternate_function, enhanced_function, feature_control;
  wire  [15:0] enhanced_mode_select, fifo_control, trigger_level;
  wire  [31:0] xon_chars, xoff_chars;
  logic [1:0]  tx_ready = 2'h0, rx_valid = 2'h0, core_tx_serial = 2'h3, rx_pin = 2'h3;
  logic [1:0]  cts_n_pin = 2'h3, dsr_n_pin = 2'h3, carrier_detect_in_n = 2'h3, ring_indicator_in_n = 2'h3;
  logic [15:0] rx_data = 16'h0000, interrupt_status_in = 16'h00F7;
  logic [15:0] line_status_in = 16'h0060, fifo_level_in = 16'h002B;
  int          n_mismatch = 0, checks_done = 0, i;
  always #2.5 core_clk = ~core_clk;
  uart_register_select_loopback dut (.*);
  host_bus_model host (.*);
  task automatic chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.acc(c, 1'h1, a, d, q);
  endtask
  task automatic rd(input logic c, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.acc(c, 1'h0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'h1;
    rd(0, 3, 8'h00);
    wr(0, 3, 8'h03);
    rd(0, 3, 8'h03);
    wr(0, 1, 8'hFF);
    rd(0, 1, 8'h0F);
    wr(0, 2, 8'hF1);
    chk(fifo_control[7:0], 8'hC1);
    rd(0, 2, 8'hC7);
    wr(0, 7, 8'hA5);
    wr(1, 7, 8'h3C);
    rd(0, 7, 8'hA5);
    rd(1, 7, 8'h3C);
    $display("test map done");
    wr(0, 3, 8'h80);
    rd(0, 0, 8'h01);
    rd(0, 1, 8'h5A);
    wr(0, 0, 8'h12);
    wr(0, 1, 8'h34);
    wr(0, 2, 8'h55);
    rd(0, 0, 8'h12);
    rd(0, 1, 8'h34);
    rd(0, 2, 8'h55);
    chk(divisor_low[7:0], 8'h12);
    chk(alternate_function[7:0], 8'h55);
    wr(0, 3, 8'hBF);
    for (i = 4; i < 8; i++) begin
      wr(0, 3'(i), 8'(i * 17));
      rd(0, 3'(i), 8'(i * 17));
    end
    chk(xon_chars[7:0], 8'h44);
    chk(xoff_chars[15:8], 8'h77);
    wr(0, 2, 8'h10);
    wr(0, 1, 8'h40);
    rd(0, 2, 8'h10);
    rd(0, 1, 8'h40);
    rd(0, 0, 8'h2B);
    wr(0, 0, 8'h5C);
    chk(trigger_level[7:0], 8'h5C);
    wr(0, 3, 8'h80);
    wr(0, 2, 8'h66);
    rd(0, 2, 8'h66);
    chk(divisor_fraction[7:0], 8'h66);
    wr(0, 3, 8'h03);
    rd(0, 7, 8'h2B);
    wr(0, 7, 8'h81);
    chk(enhanced_mode_select[7:0], 8'h81);
    wr(0, 1, 8'hFF);
    rd(0, 1, 8'hFF);
    chk(interrupt_enable[7:0], 8'hFF);
    $display("test banks done");
    rx_valid = 2'h1;
    rx_data = 16'h0011;
    @(negedge core_clk);
    rx_data = 16'h0022;
    @(negedge core_clk);
    rx_valid = 2'h0;
    @(negedge core_clk);
    chk({6'h00, rx_ready}, 8'h02);
    rd(0, 5, 8'h61);
    rd(0, 0, 8'h11);
    rd(0, 0, 8'h22);
    chk({6'h00, rx_ready}, 8'h03);
    wr(0, 0, 8'h9C);
    chk(tx_data[7:0], 8'h9C);
    chk({6'h00, tx_valid}, 8'h01);
    tx_ready = 2'h1;
    @(negedge core_clk);
    chk({6'h00, tx_valid}, 8'h00);
    $display("test stream done");
    core_tx_serial = 2'h2;
    wr(0, 4, 8'h13);
    cts_n_pin = 2'h0;
    dsr_n_pin = 2'h0;
    carrier_detect_in_n = 2'h0;
    ring_indicator_in_n = 2'h0;
    repeat (4) @(negedge core_clk);
    rd(0, 4, 8'h13);
    rd(0, 6, 8'h33);
    chk({2'h0, tx_pin, rts_n_pin, dtr_n_pin}, 8'h3F);
    chk({4'h0, core_rx_serial, flow_cts_active}, 8'h0A);
    wr(0, 4, 8'h03);
    chk({2'h0, tx_pin, rts_n_pin, dtr_n_pin}, 8'h2A);
    $display("test loop done");
    tally_and_finish();
  end
endmodule
bind uart_register_select_loopback uart_regsel_sva sva (.*);
